// ===== rtl/pgio_port.sv
// port g bidirectional gpio with peripheral pin overrides and wishbone register access
// Notes on behaviour
// - package select enables bit 4, bits 4..0, or all eight bits
// - direction bit one makes the pin an input, driver off
// - direction bit zero drives the output latch bit onto the pin
// - latch register reads return latch contents, not pin levels
// - all pins digital only, no analog path
// - enabled peripherals may force pin direction regardless of direction bit
// - overrides never stored in direction register; reads return software bits
// - pin 0 unit three compare output drives when bit zero, else capture input
// - pin 0 pwm channel a overrides port data, may tristate on shutdown
// - pin 2 with bit one feeds serial asynchronous receive input
// - pin 2 sync data output overrides port; receive needs direction bit one
// - pin 1 with bit one accepts external synchronous serial clock
// - pin 3 unit four compare output drives when bit zero, else capture input
// - pin 3 unit three pwm channel d overrides port, optional shutdown tristate
// - pin 4 unit five compare output drives when bit zero, else capture input
// - pin 4 unit one pwm channel d overrides port, optional shutdown tristate
// - write to pin value register stores into the output latches
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pgio_port (
   // system
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] pkg_sel_i,
   // wishbone slave
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic [3:0] wb_adr_i,
   input  wire logic [3:0] wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]     wb_dat_o,
   output logic            wb_ack_o,
   // pins
   input  wire logic [7:0] pin_i,
   output logic [7:0]      pin_o,
   output logic [7:0]      pin_oe_o,
   // peripheral outputs
   input  wire logic       cc3_out_i,
   input  wire logic       pwm3a_out_i,
   input  wire logic       pwm3a_tristate_i,
   input  wire logic       serial_transmit_out_i,
   input  wire logic       serial_sync_master_i,
   input  wire logic       serial_sync_clock_out_i,
   input  wire logic       serial_sync_data_out_i,
   input  wire logic       serial_sync_transmit_i,
   input  wire logic       cc4_out_i,
   input  wire logic       pwm3d_out_i,
   input  wire logic       pwm3d_tristate_i,
   input  wire logic       cc5_out_i,
   input  wire logic       pwm1d_out_i,
   input  wire logic       pwm1d_tristate_i,
   // peripheral inputs
   output logic            cc3_capture_o,
   output logic            serial_receive_in_o,
   output logic            serial_sync_clock_in_o,
   output logic            serial_sync_data_in_o,
   output logic            cc4_capture_o,
   output logic            cc5_capture_o
);
   logic [7:0] latch_reg;
   logic [7:0] dir_reg;
   logic [7:0] periph_reg;
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [1:0] pkg_reg;
   logic       ack_reg;

   // package width is caught by a clocked process so a strap never feeds the reset value
   always_ff @(posedge clk_i) begin
      pkg_reg <= pkg_sel_i;
   end

   wire logic [7:0] impl_mask = (pkg_reg == pgio_pkg::PKG_LARGE)  ? pgio_pkg::MASK_LARGE :
                                (pkg_reg == pgio_pkg::PKG_MIDDLE) ? pgio_pkg::MASK_MIDDLE :
                                pgio_pkg::MASK_SMALL;

   // bus decode
   wire logic req      = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire logic wr_lane0 = req & wb_we_i & wb_sel_i[0];
   wire logic hit_pin  = (wb_adr_i == pgio_pkg::OFFS_PIN_VALUE);
   wire logic hit_lat  = (wb_adr_i == pgio_pkg::OFFS_OUTPUT_LATCH);
   wire logic hit_dir  = (wb_adr_i == pgio_pkg::OFFS_DIRECTION);
   wire logic hit_per  = (wb_adr_i == pgio_pkg::OFFS_PERIPH_ENABLE);
   wire logic hit_pkg  = (wb_adr_i == pgio_pkg::OFFS_PKG_INFO);
   wire logic lat_wr   = wr_lane0 & (hit_pin | hit_lat);
   wire logic dir_wr   = wr_lane0 & hit_dir;
   wire logic per_wr   = wr_lane0 & hit_per;

   // absent bits are cleared in the latch and set in direction on write, and masked again on read, so a later strap change cannot corrupt held bits
   wire logic [7:0] lat_next = lat_wr ? (wb_dat_i[7:0] & impl_mask) : latch_reg;
   wire logic [7:0] dir_next = dir_wr ? ((wb_dat_i[7:0] & impl_mask) | ~impl_mask) : dir_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_reg  <= pgio_pkg::LATCH_RESET;
         dir_reg    <= pgio_pkg::DIRECTION_RESET;
         periph_reg <= pgio_pkg::PERIPH_RESET;
         ack_reg    <= 1'b0;
         sync1_reg  <= 8'h00;
         sync2_reg  <= 8'h00;
      end else begin
         latch_reg  <= lat_next;
         dir_reg    <= dir_next;
         periph_reg <= per_wr ? wb_dat_i[7:0] : periph_reg;
         ack_reg    <= req;
         sync1_reg  <= pin_i;
         sync2_reg  <= sync1_reg;
      end
   end

   // pin levels pass two flops before any read; digital only, no analog select
   wire logic [7:0] pin_level = sync2_reg & impl_mask;

   wire logic [7:0] rd_byte = hit_pin ? pin_level :
                              hit_lat ? (latch_reg & impl_mask) :
                              hit_dir ? (dir_reg & impl_mask) :
                              hit_per ? periph_reg :
                              hit_pkg ? {6'h00, pkg_reg} : 8'h00;
   logic [31:0] rdata_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (req) begin
         rdata_reg <= {24'h000000, rd_byte};
      end
   end
   assign wb_dat_o = rdata_reg;
   assign wb_ack_o = ack_reg;

   // peripheral ownership; pwm channels beat compare outputs, which beat port data
   wire logic own_pwm3a = periph_reg[pgio_pkg::EN_PWM3A];
   wire logic own_cc3   = periph_reg[pgio_pkg::EN_CC3];
   wire logic ser_en    = periph_reg[pgio_pkg::EN_SERIAL];
   wire logic ser_sync  = periph_reg[pgio_pkg::EN_SYNC];
   wire logic own_pwm3d = periph_reg[pgio_pkg::EN_PWM3D];
   wire logic own_cc4   = periph_reg[pgio_pkg::EN_CC4];
   wire logic own_pwm1d = periph_reg[pgio_pkg::EN_PWM1D];
   wire logic own_cc5   = periph_reg[pgio_pkg::EN_CC5];

   // pin 1: async transmit out, or sync clock out in master mode; slave clock is input
   wire logic p1_drive = ser_en & (~ser_sync | serial_sync_master_i);
   wire logic p1_val   = ser_sync ? serial_sync_clock_out_i : serial_transmit_out_i;
   // pin 2: sync data out only while transmitting; receive follows direction bit
   wire logic p2_drive = ser_en & ser_sync & serial_sync_transmit_i;

   logic [7:0] drv_val;
   logic [7:0] drv_en;
   always_comb begin
      drv_val = latch_reg;
      drv_en  = ~dir_reg;
      if (own_pwm3a) begin
         drv_val[pgio_pkg::PIN_CC3] = pwm3a_out_i;
         drv_en[pgio_pkg::PIN_CC3]  = ~pwm3a_tristate_i;
      end else if (own_cc3) begin
         drv_val[pgio_pkg::PIN_CC3] = cc3_out_i;
      end
      if (p1_drive) begin
         drv_val[pgio_pkg::PIN_SCLK] = p1_val;
         drv_en[pgio_pkg::PIN_SCLK]  = 1'b1;
      end else if (ser_en & ser_sync) begin
         drv_en[pgio_pkg::PIN_SCLK] = 1'b0;
      end
      if (p2_drive) begin
         drv_val[pgio_pkg::PIN_SDATA] = serial_sync_data_out_i;
         drv_en[pgio_pkg::PIN_SDATA]  = 1'b1;
      end
      if (own_pwm3d) begin
         drv_val[pgio_pkg::PIN_CC4] = pwm3d_out_i;
         drv_en[pgio_pkg::PIN_CC4]  = ~pwm3d_tristate_i;
      end else if (own_cc4) begin
         drv_val[pgio_pkg::PIN_CC4] = cc4_out_i;
      end
      if (own_pwm1d) begin
         drv_val[pgio_pkg::PIN_CC5] = pwm1d_out_i;
         drv_en[pgio_pkg::PIN_CC5]  = ~pwm1d_tristate_i;
      end else if (own_cc5) begin
         drv_val[pgio_pkg::PIN_CC5] = cc5_out_i;
      end
   end

   // pin outputs from flops; unimplemented pins never drive
   logic [7:0] pin_out_reg;
   logic [7:0] pin_oe_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_reg <= 8'h00;
         pin_oe_reg  <= 8'h00;
      end else begin
         pin_out_reg <= drv_val & impl_mask;
         pin_oe_reg  <= drv_en & impl_mask;
      end
   end
   assign pin_o    = pin_out_reg;
   assign pin_oe_o = pin_oe_reg;

   // capture and serial inputs only see the pin while its direction bit is one
   wire logic [7:0] in_ok = dir_reg & pin_level;
   assign cc3_capture_o          = in_ok[pgio_pkg::PIN_CC3] & own_cc3;
   assign serial_sync_clock_in_o = in_ok[pgio_pkg::PIN_SCLK] & ser_en & ser_sync & ~serial_sync_master_i;
   assign serial_receive_in_o    = ser_en & ~ser_sync & in_ok[pgio_pkg::PIN_SDATA];
   assign serial_sync_data_in_o  = ser_en & ser_sync & in_ok[pgio_pkg::PIN_SDATA];
   assign cc4_capture_o          = in_ok[pgio_pkg::PIN_CC4] & own_cc4;
   assign cc5_capture_o          = in_ok[pgio_pkg::PIN_CC5] & own_cc5;
endmodule
`default_nettype wire

// ===== rtl/pgio_pkg.sv
// package with register map, reset values and package-width masks for the port g block
package pgio_pkg;
   localparam int unsigned PORT_WIDTH = 8;
   localparam logic [3:0] OFFS_PIN_VALUE = 4'h0;
   localparam logic [3:0] OFFS_OUTPUT_LATCH = 4'h4;
   localparam logic [3:0] OFFS_DIRECTION = 4'h8;
   localparam logic [3:0] OFFS_PERIPH_ENABLE = 4'hc;
   // read-only package code; the four-bit bus address leaves no room above 0xf
   localparam logic [3:0] OFFS_PKG_INFO = 4'h1;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'hff;
   localparam logic [7:0] PERIPH_RESET = 8'h00;
   localparam logic [1:0] PKG_SMALL = 2'h0;
   localparam logic [1:0] PKG_MIDDLE = 2'h1;
   localparam logic [1:0] PKG_LARGE = 2'h2;
   localparam logic [7:0] MASK_SMALL = 8'h10;
   localparam logic [7:0] MASK_MIDDLE = 8'h1f;
   localparam logic [7:0] MASK_LARGE = 8'hff;
   localparam int unsigned PIN_CC3 = 0;
   localparam int unsigned PIN_SCLK = 1;
   localparam int unsigned PIN_SDATA = 2;
   localparam int unsigned PIN_CC4 = 3;
   localparam int unsigned PIN_CC5 = 4;
   localparam int unsigned EN_CC3 = 0;
   localparam int unsigned EN_PWM3A = 1;
   localparam int unsigned EN_SERIAL = 2;
   localparam int unsigned EN_SYNC = 3;
   localparam int unsigned EN_CC4 = 4;
   localparam int unsigned EN_PWM3D = 5;
   localparam int unsigned EN_CC5 = 6;
   localparam int unsigned EN_PWM1D = 7;
endpackage

// ===== sim/pgio_properties.sv
// checker for the port g block bus timing and package masking
`timescale 1ns/1ps
`default_nettype none
module pgio_checker (
   // system
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [1:0]  pkg_sel_i,
   // bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // pins
   input wire logic [7:0]  pin_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence small_s;
      pkg_sel_i == pgio_pkg::PKG_SMALL && $past(pkg_sel_i) == pgio_pkg::PKG_SMALL
         && $past(pkg_sel_i, 2) == pgio_pkg::PKG_SMALL;
   endsequence
   a_ack_after_take: assert property (take_s |=> wb_ack_o) else $error("no ack after request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   a_rdata_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
   a_rdata_held: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o)) else $error("data moved");
   a_small_oe_mask: assert property (small_s |=> (pin_oe_o & ~pgio_pkg::MASK_SMALL) == 8'h00)
      else $error("absent pin driven");
   a_mid_oe_mask: assert property (pkg_sel_i == pgio_pkg::PKG_MIDDLE ##1 pkg_sel_i == pgio_pkg::PKG_MIDDLE
      |=> (pin_oe_o & ~pgio_pkg::MASK_MIDDLE) == 8'h00) else $error("absent pin driven");
   a_small_read_zero: assert property ((wb_ack_o && !wb_we_i && wb_adr_i != pgio_pkg::OFFS_PIN_VALUE)
      and small_s |-> (wb_dat_o[7:0] & ~pgio_pkg::MASK_SMALL) == 8'h00) else $error("absent bit read");
endmodule
bind pgio_port pgio_checker pgio_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .pkg_sel_i(pkg_sel_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

// ===== sim/pgio_board.sv
// board model: each pin carries the port drive where enabled, else the board's own level
`timescale 1ns/1ps
`default_nettype none
module pgio_board (
   input  wire logic [7:0] pin_o,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_val,
   output logic [7:0]      pin_lvl
);
   assign pin_lvl = (pin_o & pin_oe) | (ext_val & ~pin_oe);
endmodule
`default_nettype wire

// ===== sim/pgio_port_tb_top.sv
// testbench for the port g block: register accesses over the bus, checks at pins
`timescale 1ns/1ps
`default_nettype none
module pgio_port_tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [1:0]  pkg = pgio_pkg::PKG_LARGE;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0, dat_o, rdat;
   logic        ack;
   logic [7:0]  lvl, pin_o, pin_oe, ext = 8'h3e;
   logic [13:0] per = 14'h0;
   logic [5:0]  cap;
   int          err_total = 0, n_checks = 0, ticks = 0;
   always #12.5 clk_i = ~clk_i;
   pgio_port pgio_port_inst (.clk_i(clk_i), .rst_i(rst_i), .pkg_sel_i(pkg), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .pin_i(lvl), .pin_o(pin_o), .pin_oe_o(pin_oe), .cc3_out_i(per[0]), .pwm3a_out_i(per[1]),
      .pwm3a_tristate_i(per[2]), .serial_transmit_out_i(per[3]), .serial_sync_master_i(per[4]),
      .serial_sync_clock_out_i(per[5]), .serial_sync_data_out_i(per[6]), .serial_sync_transmit_i(per[7]),
      .cc4_out_i(per[8]), .pwm3d_out_i(per[9]), .pwm3d_tristate_i(per[10]), .cc5_out_i(per[11]),
      .pwm1d_out_i(per[12]), .pwm1d_tristate_i(per[13]), .cc3_capture_o(cap[0]), .serial_receive_in_o(cap[1]),
      .serial_sync_clock_in_o(cap[2]), .serial_sync_data_in_o(cap[3]), .cc4_capture_o(cap[4]),
      .cc5_capture_o(cap[5]));
   pgio_board pgio_board_inst (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext), .pin_lvl(lvl));
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // three idle edges after each access let pin drive and the input synchroniser settle
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check(rdat, {24'h0, e});
   endtask
   always @(posedge clk_i) begin
      ticks++;
      if (ticks == 2000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(pgio_pkg::OFFS_DIRECTION, pgio_pkg::DIRECTION_RESET);
      rd(pgio_pkg::OFFS_OUTPUT_LATCH, pgio_pkg::LATCH_RESET);
      rd(pgio_pkg::OFFS_PERIPH_ENABLE, pgio_pkg::PERIPH_RESET);
      bus(1'b1, pgio_pkg::OFFS_OUTPUT_LATCH, 8'ha5);
      bus(1'b1, pgio_pkg::OFFS_DIRECTION, 8'hf0);
      check({pin_oe, pin_o & 8'h0f}, 16'h0f05);
      rd(pgio_pkg::OFFS_PIN_VALUE, 8'h35);
      rd(pgio_pkg::OFFS_OUTPUT_LATCH, 8'ha5);
      bus(1'b1, pgio_pkg::OFFS_PIN_VALUE, 8'h42);
      rd(pgio_pkg::OFFS_OUTPUT_LATCH, 8'h42);
      rd(4'h2, 8'h00);
      bus(1'b1, pgio_pkg::OFFS_DIRECTION, 8'he0);
      per <= 14'h0901;
      bus(1'b1, pgio_pkg::OFFS_PERIPH_ENABLE, 8'h51);
      check(pin_o & 8'h19, 8'h19);
      bus(1'b1, pgio_pkg::OFFS_PERIPH_ENABLE, 8'hf3);
      check(pin_o & 8'h19, 8'h00);
      per <= 14'h2d05;
      rd(pgio_pkg::OFFS_DIRECTION, 8'he0);
      check(pin_oe & 8'h19, 8'h00);
      bus(1'b1, pgio_pkg::OFFS_DIRECTION, 8'hff);
      bus(1'b1, pgio_pkg::OFFS_PERIPH_ENABLE, 8'h51);
      check(cap & 6'h31, 6'h30);
      per <= 14'h0008;
      bus(1'b1, pgio_pkg::OFFS_PERIPH_ENABLE, 8'h04);
      check({pin_oe[1], pin_o[1], cap[1]}, 3'b111);
      bus(1'b1, pgio_pkg::OFFS_PERIPH_ENABLE, 8'h0c);
      check({pin_oe[1], cap[2]}, 2'b01);
      per <= 14'h00c8;
      rd(pgio_pkg::OFFS_DIRECTION, 8'hff);
      check({pin_oe[2], pin_o[2]}, 2'b11);
      bus(1'b1, pgio_pkg::OFFS_PERIPH_ENABLE, 8'h00);
      pkg <= pgio_pkg::PKG_SMALL;
      rd(pgio_pkg::OFFS_DIRECTION, pgio_pkg::MASK_SMALL);
      bus(1'b1, pgio_pkg::OFFS_DIRECTION, 8'h00);
      check(pin_oe, pgio_pkg::MASK_SMALL);
      pkg <= pgio_pkg::PKG_MIDDLE;
      rd(pgio_pkg::OFFS_OUTPUT_LATCH, 8'h02);
      bus(1'b1, pgio_pkg::OFFS_DIRECTION, 8'h00);
      check(pin_oe, pgio_pkg::MASK_MIDDLE);
      close_out();
   end
endmodule
`default_nettype wire
